// ===== core/bfs_dual_queue.sv
// two opposite queues with port b sizing, byte swap and per-port flags
//
// Notes on behaviour
// RULE1 - byte reads follow swap order per endian lane
// RULE2 - right empty rises next right edge after write
// RULE3 - right empty falls on last sub-read
// RULE4 - left empty rises next left edge after write
// RULE5 - partial right writes count only when complete
// RULE6 - left full rises next left edge after read
// RULE7 - right full falls on completing sub-write
// RULE8 - right full rises next right edge after read
// RULE9 - right almost-empty rises next right edge
// RULE10 - right almost-empty falls on completing sub-read
// RULE11 - left almost-empty rises next left edge
// RULE12 - left almost-full rises next left edge
// RULE13 - right almost-full rises next right edge
// RULE14 - right almost-full falls only on completion
// RULE15 - a-to-b queue access codes per port
// RULE16 - b-to-a queue access codes per port
// RULE17 - both size selects low mean long word
// RULE18 - right parity passes through when generation off
// RULE19 - left parity passes through when generation off
// RULE20 - both size selects high write the mailbox
// RULE21 - unused right lanes hold last output
// RULE22 - flags active low, change on own port edge
`timescale 1ns/1ns
module bfs_dual_queue (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // left port
  input wire logic left_port_clock,
  input wire bfs_pkg::bfs_ctl_t leftCtl,
  input wire logic left_parity_gen_en,
  input wire logic [35:0] leftDataIn,
  output logic [35:0] leftDataOut,
  output logic left_empty_n,
  output logic left_full_n,
  output logic left_almost_empty_n,
  output logic left_almost_full_n,
  // right port
  input wire logic right_port_clock,
  input wire bfs_pkg::bfs_ctl_t rightCtl,
  input wire logic right_size_sel_lo,
  input wire logic right_size_sel_hi,
  input wire logic swap_sel_lo,
  input wire logic swap_sel_hi,
  input wire logic rightBigEndian,
  input wire logic right_parity_gen_en,
  input wire logic [35:0] rightDataIn,
  output logic [35:0] rightDataOut,
  output logic right_empty_n,
  output logic right_full_n,
  output logic right_almost_empty_n,
  output logic right_almost_full_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [bfs_pkg::CNT_W-1:0] FULL_CNT = bfs_pkg::CNT_W'(bfs_pkg::DEPTH);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte order swap; every mode is its own inverse, so writes reuse it
  function automatic logic [35:0] swapLong(input logic [35:0] d, input logic [1:0] sel);
    unique case (sel)
      2'b00: swapLong = d;
      2'b01: swapLong = {d[8:0], d[17:9], d[26:18], d[35:27]};
      2'b10: swapLong = {d[17:0], d[35:18]};
      2'b11: swapLong = {d[26:18], d[35:27], d[8:0], d[17:9]};
    endcase
  endfunction

  // odd parity into bit 8 of each byte when enabled, else bits as stored
  function automatic logic [35:0] parGen(input logic [35:0] d, input logic en);
    logic [35:0] r;
    r = d;
    for (int i = 0; i < 4; i++) begin
      if (en) begin
        r[9*i+8] = ~^d[9*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  bfs_pkg::bfs_size_t rightSize; // port b bus size
  logic [1:0] swapSel; // port b swap mode
  logic [1:0] rdSub_reg; // sub-read index within a long word
  logic [1:0] wrSub_reg; // sub-write index within a long word
  logic [35:0] wrAsm_reg; // partial long word from port b
  logic [35:0] wrAsm_next;
  logic rdLast, wrLast; // sub-transfer ends the long word
  logic aSel, aPush, aPop, aMbWr, aMbRd; // left port actions
  logic bSel, bMail, bRdStep, bWrStep, bPush, bPop, bMbWr, bMbRd; // right port actions
  logic [35:0] abHead, baHead; // queue heads
  logic [bfs_pkg::CNT_W-1:0] abCount, baCount; // queue occupancy
  logic [35:0] abMail_reg, baMail_reg; // mailboxes
  logic [35:0] bSwapped; // swapped and parity-handled a-to-b head
  logic [8:0] bByte; // byte piece for this sub-read
  logic [17:0] bWord; // word piece for this sub-read
  logic [5:0] aeOffs_reg, afOffs_reg; // almost thresholds

  assign rightSize = bfs_pkg::bfs_size_t'({right_size_sel_hi, right_size_sel_lo}); // RULE17
  assign swapSel = {swap_sel_hi, swap_sel_lo};
  // left port gated by its own edge and select; queue accesses also by their flag
  assign aSel = left_port_clock & ~leftCtl.selectN;
  assign aPush = aSel & leftCtl.writeNotRead & ~leftCtl.mailboxSelect & left_full_n; // RULE15
  assign aPop = aSel & ~leftCtl.writeNotRead & ~leftCtl.mailboxSelect & left_empty_n; // RULE16
  assign aMbWr = aSel & leftCtl.writeNotRead & leftCtl.mailboxSelect;
  assign aMbRd = aSel & ~leftCtl.writeNotRead & leftCtl.mailboxSelect;
  // right port: size code 11 also routes to the mailbox
  assign bSel = right_port_clock & ~rightCtl.selectN;
  assign bMail = rightCtl.mailboxSelect | (rightSize == bfs_pkg::SZ_MAIL); // RULE20
  assign bRdStep = bSel & ~rightCtl.writeNotRead & ~bMail & right_empty_n; // RULE15
  assign bWrStep = bSel & rightCtl.writeNotRead & ~bMail & right_full_n; // RULE16
  assign bMbWr = bSel & rightCtl.writeNotRead & bMail;
  assign bMbRd = bSel & ~rightCtl.writeNotRead & bMail;
  assign rdLast = (rightSize == bfs_pkg::SZ_LONG) ||
                  (rightSize == bfs_pkg::SZ_WORD && rdSub_reg == bfs_pkg::SUB_WORD_LAST) ||
                  (rightSize == bfs_pkg::SZ_BYTE && rdSub_reg == bfs_pkg::SUB_BYTE_LAST);
  assign wrLast = (rightSize == bfs_pkg::SZ_LONG) ||
                  (rightSize == bfs_pkg::SZ_WORD && wrSub_reg == bfs_pkg::SUB_WORD_LAST) ||
                  (rightSize == bfs_pkg::SZ_BYTE && wrSub_reg == bfs_pkg::SUB_BYTE_LAST);
  // the queue only moves when a long word completes
  assign bPop = bRdStep & rdLast; // RULE3 RULE10
  assign bPush = bWrStep & wrLast; // RULE5 RULE7 RULE14

  // ----------------------------------------
  // queues
  // ----------------------------------------
  bfs_queue #(.WIDTH(bfs_pkg::WORD_W), .DEPTH(bfs_pkg::DEPTH), .CNT_W(bfs_pkg::CNT_W)) uAtoB (
    .clk(mclk),
    .rst(sys_rst),
    .push(aPush),
    .pushData(leftDataIn),
    .pop(bPop),
    .headData(abHead),
    .count(abCount)
  );

  bfs_queue #(.WIDTH(bfs_pkg::WORD_W), .DEPTH(bfs_pkg::DEPTH), .CNT_W(bfs_pkg::CNT_W)) uBtoA (
    .clk(mclk),
    .rst(sys_rst),
    .push(bPush),
    .pushData(swapLong(wrAsm_next, swapSel)),
    .pop(aPop),
    .headData(baHead),
    .count(baCount)
  );

  // ----------------------------------------
  // port b sub-word handling
  // ----------------------------------------
  // big-endian takes pieces from the top lanes, little-endian from the bottom
  assign bSwapped = parGen(swapLong(abHead, swapSel), right_parity_gen_en); // RULE1 RULE18
  assign bByte = bSwapped[(rightBigEndian ? 27 - 9 * int'(rdSub_reg) : 9 * int'(rdSub_reg)) +: 9]; // RULE1
  assign bWord = bSwapped[(rightBigEndian ? 18 - 18 * int'(rdSub_reg[0]) : 18 * int'(rdSub_reg[0])) +: 18];

  // place the incoming piece into the long word being built
  always_comb begin
    wrAsm_next = wrAsm_reg;
    unique case (rightSize)
      bfs_pkg::SZ_BYTE: begin
        wrAsm_next[(rightBigEndian ? 27 - 9 * int'(wrSub_reg) : 9 * int'(wrSub_reg)) +: 9] =
          rightBigEndian ? rightDataIn[35:27] : rightDataIn[8:0];
      end
      bfs_pkg::SZ_WORD: begin
        wrAsm_next[(rightBigEndian ? 18 - 18 * int'(wrSub_reg[0]) : 18 * int'(wrSub_reg[0])) +: 18] =
          rightBigEndian ? rightDataIn[35:18] : rightDataIn[17:0];
      end
      default: begin
        wrAsm_next = rightDataIn;
      end
    endcase
  end

  // sub-transfer counters restart after each completed long word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdSub_reg <= 2'h0;
      wrSub_reg <= 2'h0;
      wrAsm_reg <= 36'h0;
    end else begin
      if (bRdStep) begin
        rdSub_reg <= rdLast ? 2'h0 : rdSub_reg + 2'h1;
      end
      if (bWrStep) begin
        wrSub_reg <= wrLast ? 2'h0 : wrSub_reg + 2'h1;
        wrAsm_reg <= wrAsm_next;
      end
    end
  end

  // ----------------------------------------
  // read data and mailboxes
  // ----------------------------------------
  // right output: unused lanes keep their last value on partial reads
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rightDataOut <= 36'h0;
    end else if (bRdStep) begin
      unique case (rightSize)
        bfs_pkg::SZ_BYTE: begin
          if (rightBigEndian) begin
            rightDataOut[35:27] <= bByte; // RULE21
          end else begin
            rightDataOut[8:0] <= bByte;
          end
        end
        bfs_pkg::SZ_WORD: begin
          if (rightBigEndian) begin
            rightDataOut[35:18] <= bWord; // RULE21
          end else begin
            rightDataOut[17:0] <= bWord;
          end
        end
        default: begin
          rightDataOut <= bSwapped;
        end
      endcase
    end else if (bMbRd) begin
      rightDataOut <= parGen(abMail_reg, right_parity_gen_en);
    end
  end

  // left output from the b-to-a queue or mailbox
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      leftDataOut <= 36'h0;
    end else if (aPop) begin
      leftDataOut <= parGen(baHead, left_parity_gen_en); // RULE19
    end else if (aMbRd) begin
      leftDataOut <= parGen(baMail_reg, left_parity_gen_en);
    end
  end

  // mailbox registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      abMail_reg <= 36'h0;
      baMail_reg <= 36'h0;
    end else begin
      if (aMbWr) begin
        abMail_reg <= leftDataIn;
      end
      if (bMbWr) begin
        baMail_reg <= rightDataIn; // RULE20
      end
    end
  end

  // ----------------------------------------
  // flags
  // ----------------------------------------
  // each flag samples occupancy at its own port edge; a far-side move that
  // lands on the same cycle shows one port cycle later
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      left_empty_n <= 1'b0;
      left_almost_empty_n <= 1'b0;
      left_full_n <= 1'b1;
      left_almost_full_n <= 1'b1;
    end else if (left_port_clock) begin // RULE22
      left_empty_n <= (baCount - bfs_pkg::CNT_W'(aPop)) != '0; // RULE4
      left_almost_empty_n <= (baCount - bfs_pkg::CNT_W'(aPop)) > bfs_pkg::CNT_W'(aeOffs_reg); // RULE11
      left_full_n <= (abCount + bfs_pkg::CNT_W'(aPush)) != FULL_CNT; // RULE6
      left_almost_full_n <= (abCount + bfs_pkg::CNT_W'(aPush)) <
                            FULL_CNT - bfs_pkg::CNT_W'(afOffs_reg); // RULE12
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      right_empty_n <= 1'b0;
      right_almost_empty_n <= 1'b0;
      right_full_n <= 1'b1;
      right_almost_full_n <= 1'b1;
    end else if (right_port_clock) begin // RULE22
      right_empty_n <= (abCount - bfs_pkg::CNT_W'(bPop)) != '0; // RULE2 RULE3
      right_almost_empty_n <= (abCount - bfs_pkg::CNT_W'(bPop)) > bfs_pkg::CNT_W'(aeOffs_reg); // RULE9 RULE10
      right_full_n <= (baCount + bfs_pkg::CNT_W'(bPush)) != FULL_CNT; // RULE7 RULE8
      right_almost_full_n <= (baCount + bfs_pkg::CNT_W'(bPush)) <
                             FULL_CNT - bfs_pkg::CNT_W'(afOffs_reg); // RULE13 RULE14
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic awHeld_reg, wHeld_reg; // address or data taken, waiting for the other
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic [31:0] statWord; // live status view

  assign statWord = {8'h00, left_empty_n, left_full_n, left_almost_empty_n, left_almost_full_n,
                     right_empty_n, right_full_n, right_almost_empty_n, right_almost_full_n,
                     1'b0, baCount, 1'b0, abCount};

  // write path: address and data in either order, answer after both
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bfs_pkg::RESP_OKAY;
      aeOffs_reg <= bfs_pkg::AE_OFFS_RST;
      afOffs_reg <= bfs_pkg::AF_OFFS_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
        awHeld_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHeld_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (awHeld_reg && wHeld_reg && !s_axi_bvalid) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr_reg == bfs_pkg::CTRL_OFFS) begin
          s_axi_bresp <= bfs_pkg::RESP_OKAY;
          if (wStrb_reg[0]) begin
            aeOffs_reg <= wData_reg[bfs_pkg::AE_POS +: 6];
          end
          if (wStrb_reg[1]) begin
            afOffs_reg <= wData_reg[bfs_pkg::AF_POS +: 6];
          end
        end else if (awAddr_reg == bfs_pkg::STAT_OFFS) begin
          s_axi_bresp <= bfs_pkg::RESP_OKAY; // status ignores writes
        end else begin
          s_axi_bresp <= bfs_pkg::RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read path: one read at a time, answer the cycle after the address
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= bfs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == bfs_pkg::CTRL_OFFS) begin
        s_axi_rdata <= {18'h0, afOffs_reg, 2'h0, aeOffs_reg};
        s_axi_rresp <= bfs_pkg::RESP_OKAY;
      end else if (s_axi_araddr == bfs_pkg::STAT_OFFS) begin
        s_axi_rdata <= statWord;
        s_axi_rresp <= bfs_pkg::RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= bfs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_rbyte_swap_order: assert property (bRdStep && rightSize == bfs_pkg::SZ_BYTE && rightBigEndian // RULE1
    |=> rightDataOut[35:27] == $past(bSwapped[27 - 9 * int'(rdSub_reg) +: 9]))
    else $error("right byte lane order wrong");
  a_rempty_rise: assert property (right_port_clock && !bPop && abCount != '0 |=> right_empty_n) // RULE2
    else $error("right empty did not rise");
  a_rempty_last_read: assert property (bPop && abCount == 7'h01 |=> !right_empty_n) // RULE3
    else $error("right empty did not fall on last read");
  a_lempty_rise: assert property (left_port_clock && !aPop && baCount != '0 |=> left_empty_n) // RULE4
    else $error("left empty did not rise");
  a_partial_no_push: assert property (bWrStep && !wrLast |-> !bPush) // RULE5
    else $error("partial right write pushed");
  a_lfull_rise: assert property (left_port_clock && !aPush && abCount != FULL_CNT |=> left_full_n) // RULE6
    else $error("left full did not rise");
  a_rfull_fall: assert property (bPush && baCount == FULL_CNT - 7'h01 && !aPop |=> !right_full_n) // RULE7
    else $error("right full did not fall");
  a_rfull_rise: assert property (right_port_clock && !bPush && baCount != FULL_CNT |=> right_full_n) // RULE8
    else $error("right full did not rise");
  a_rae_rise: assert property (right_port_clock && !bPop && abCount > 7'(aeOffs_reg) // RULE9
    |=> right_almost_empty_n)
    else $error("right almost-empty did not rise");
  a_rae_fall: assert property (bPop && abCount == 7'(aeOffs_reg) + 7'h01 |=> !right_almost_empty_n) // RULE10
    else $error("right almost-empty did not fall");
  a_lae_rise: assert property (left_port_clock && !aPop && baCount > 7'(aeOffs_reg) // RULE11
    |=> left_almost_empty_n)
    else $error("left almost-empty did not rise");
  a_laf_rise: assert property (left_port_clock && !aPush && abCount < FULL_CNT - 7'(afOffs_reg) // RULE12
    |=> left_almost_full_n)
    else $error("left almost-full did not rise");
  a_raf_rise: assert property (right_port_clock && !bPush && baCount < FULL_CNT - 7'(afOffs_reg) // RULE13
    |=> right_almost_full_n)
    else $error("right almost-full did not rise");
  a_raf_hold: assert property (right_port_clock && bWrStep && !wrLast && !aPop // RULE14
    |=> right_almost_full_n == $past(baCount < FULL_CNT - 7'(afOffs_reg)))
    else $error("right almost-full moved on partial write");
  a_rlong_pass: assert property (bRdStep && rightSize == bfs_pkg::SZ_LONG && !right_parity_gen_en // RULE18
    |=> rightDataOut == $past(swapLong(abHead, swapSel)))
    else $error("right parity not passed through");
  a_lread_pass: assert property (aPop && !left_parity_gen_en |=> leftDataOut == $past(baHead)) // RULE19
    else $error("left parity not passed through");
  a_mail_size: assert property (bSel && rightCtl.writeNotRead && rightSize == bfs_pkg::SZ_MAIL // RULE20
    |=> baMail_reg == $past(rightDataIn) && baCount == $past(baCount) - 7'($past(aPop)))
    else $error("mailbox size write misrouted");
  a_lane_hold: assert property (bRdStep && rightSize == bfs_pkg::SZ_BYTE && rightBigEndian // RULE21
    |=> rightDataOut[26:0] == $past(rightDataOut[26:0]))
    else $error("unused right lanes changed");
  a_flag_own_edge: assert property ($changed(left_empty_n) || $changed(left_full_n) // RULE22
    |-> $past(left_port_clock))
    else $error("left flag moved off its edge");
  c_byte_read_done: cover property (bPop && rightSize == bfs_pkg::SZ_BYTE);
  c_word_write_done: cover property (bPush && rightSize == bfs_pkg::SZ_WORD);
  c_queue_full: cover property (!left_full_n);
  c_mail_write: cover property (bMbWr);
endmodule

// ===== core/bfs_pkg.sv
// shared constants and types for the dual queue block
package bfs_pkg;
  // ----------------------------------------
  // storage geometry
  // ----------------------------------------
  localparam int DEPTH = 64; // long words per queue
  localparam int WORD_W = 36; // long word width
  localparam int CNT_W = 7; // occupancy counter width
  // ----------------------------------------
  // register map and reset values
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFFS = 8'h00; // almost-empty / almost-full offsets
  localparam logic [7:0] STAT_OFFS = 8'h04; // counts and flags
  localparam int AE_POS = 0; // almost-empty offset field
  localparam int AF_POS = 8; // almost-full offset field
  localparam logic [5:0] AE_OFFS_RST = 6'h08;
  localparam logic [5:0] AF_OFFS_RST = 6'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // port b sizing
  // ----------------------------------------
  localparam logic [1:0] SUB_WORD_LAST = 2'h1; // second word ends a long word
  localparam logic [1:0] SUB_BYTE_LAST = 2'h3; // fourth byte ends a long word
  typedef enum logic [1:0] {
    SZ_LONG = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_WORD = 2'b10,
    SZ_MAIL = 2'b11
  } bfs_size_t;
  // port control pins travelling together
  typedef struct packed {
    logic selectN; // low selects the port
    logic writeNotRead; // high writes
    logic mailboxSelect; // high addresses the mailbox
  } bfs_ctl_t;
endpackage

// ===== core/bfs_queue.sv
// one long-word queue with occupancy count
`timescale 1ns/1ns
module bfs_queue #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 64,
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic push,
  input wire logic [WIDTH-1:0] pushData,
  // drain side
  input wire logic pop,
  output logic [WIDTH-1:0] headData,
  output logic [CNT_W-1:0] count
);
  localparam int ADDR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage, depth must be a power of two
  logic [ADDR_W-1:0] wrPtr_reg; // next slot to fill
  logic [ADDR_W-1:0] rdPtr_reg; // oldest slot
  logic [CNT_W-1:0] count_reg; // words held

  // ----------------------------------------
  // storage and pointers
  // ----------------------------------------
  // writes never reach a full queue, the caller gates them
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= pushData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= CNT_W'(count_reg + CNT_W'(push) - CNT_W'(pop));
    end
  end

  assign headData = mem[rdPtr_reg];
  assign count = count_reg;
endmodule

// ===== testbench/bfs_port_master.sv
// port bus master model: one port clock edge per request
`timescale 1ns/1ns
module bfs_port_master (
  // clock
  input wire logic mclk,
  // request from bench
  input wire logic go,
  input wire bfs_pkg::bfs_ctl_t ctlIn,
  input wire logic [35:0] dIn,
  // port pins
  output logic portClk,
  output bfs_pkg::bfs_ctl_t ctl,
  output logic [35:0] dOut
);
  // outside a request the port is deselected and the data lines show the inverse
  always_ff @(posedge mclk) begin
    portClk <= go;
    ctl <= go ? ctlIn : 3'h4;
    dOut <= go ? dIn : ~dIn;
  end
endmodule

// ===== testbench/bfs_dual_queue_tb.sv
// self-checking bench for the dual queue block
`timescale 1ns/1ns
module bfs_dual_queue_tb;
  // --------------------
  // pins and counters
  // --------------------
  logic mclk = 1'h0, sys_rst = 1'h1, lGo = 1'h0, rGo = 1'h0, left_port_clock, right_port_clock;
  bfs_pkg::bfs_ctl_t lReq = 3'h4, rReq = 3'h4, leftCtl, rightCtl;
  logic [35:0] lD = 36'h0, rD = 36'h0, leftDataIn, rightDataIn, leftDataOut, rightDataOut;
  logic left_parity_gen_en = 1'h0, right_parity_gen_en = 1'h0, rightBigEndian = 1'h1;
  logic right_size_sel_lo = 1'h1, right_size_sel_hi = 1'h0, swap_sel_lo = 1'h0, swap_sel_hi = 1'h0;
  logic left_empty_n, left_full_n, left_almost_empty_n, left_almost_full_n;
  logic right_empty_n, right_full_n, right_almost_empty_n, right_almost_full_n;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int err_count = 0, n_compared = 0;
  always #25 mclk = ~mclk;
  bfs_dual_queue bfs_dual_queue_inst (.*);
  bfs_port_master leftMaster (.mclk, .go(lGo), .ctlIn(lReq), .dIn(lD), .portClk(left_port_clock), .ctl(leftCtl),
    .dOut(leftDataIn));
  bfs_port_master rightMaster (.mclk, .go(rGo), .ctlIn(rReq), .dIn(rD), .portClk(right_port_clock),
    .ctl(rightCtl), .dOut(rightDataIn));
  // --------------------
  // tasks
  // --------------------
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one port access (side 1 = right), results sampled once settled
  task automatic acc(input logic side, input logic [2:0] c, input logic [35:0] d);
    @(posedge mclk);
    if (side) begin
      {rReq, rD, rGo} <= {c, d, 1'h1};
    end else begin
      {lReq, lD, lGo} <= {c, d, 1'h1};
    end
    @(posedge mclk);
    {lGo, rGo} <= 2'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  // one register access, held until the answer is sampled
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic [1:0] rs);
    @(posedge mclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, wd};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!(s_axi_bready && s_axi_bvalid) && !(s_axi_rready && s_axi_rvalid));
    {s_axi_bready, s_axi_rready} <= 2'h0;
    rd = s_axi_rdata;
    rs = wr ? s_axi_bresp : s_axi_rresp;
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // --------------------
  // tests
  // --------------------
  initial begin
    logic [31:0] rd;
    logic [1:0] rs;
    logic [35:0] w;
    int p;
    w = 36'h9a5c3e781;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'h0;
    #1;
    chk("reset flags", 36'h3, {left_empty_n, right_empty_n, left_full_n, right_full_n});
    // byte reads in every swap mode on both lanes
    for (int m = 0; m < 8; m++) begin
      {rightBigEndian, swap_sel_hi, swap_sel_lo} <= {!m[2], m[1:0]};
      acc(1'h0, 3'h2, w + m);
      chk("right empty", 36'h0, right_empty_n);
      acc(1'h1, 3'h4, w);
      chk("right empty", 36'h1, right_empty_n);
      for (int k = 0; k < 4; k++) begin
        acc(1'h1, 3'h0, w);
        p = k ^ ((4 - m) & 3) ^ (m[2] ? 3 : 0);
        chk("byte", (w + m) >> (27 - 9 * p) & 36'h1ff, m[2] ? rightDataOut[8:0] : rightDataOut[35:27]);
        chk("right empty", k < 3, right_empty_n);
      end
    end
    // long word from right to left
    {right_size_sel_lo, swap_sel_hi, swap_sel_lo} <= 3'h0;
    acc(1'h1, 3'h2, w);
    chk("left empty", 36'h0, left_empty_n);
    acc(1'h0, 3'h4, w);
    chk("left empty", 36'h1, left_empty_n);
    acc(1'h0, 3'h0, w);
    chk("left data", w, leftDataOut);
    // fill the left-to-right queue, then free one place
    repeat (64) acc(1'h0, 3'h2, w);
    chk("left full", 36'h0, {left_full_n, left_almost_full_n});
    acc(1'h1, 3'h4, w);
    chk("right ae", 36'h1, right_almost_empty_n);
    acc(1'h1, 3'h0, w);
    acc(1'h0, 3'h4, w);
    chk("left full", 36'h1, left_full_n);
    // two little-endian word writes form one long word
    {right_size_sel_hi, right_size_sel_lo, rightBigEndian} <= 3'h4;
    acc(1'h1, 3'h2, w);
    acc(1'h0, 3'h4, w);
    chk("left empty", 36'h0, left_empty_n);
    acc(1'h1, 3'h2, 36'h5);
    acc(1'h0, 3'h4, w);
    chk("left empty", 36'h1, left_empty_n);
    acc(1'h0, 3'h0, w);
    chk("word pair", {18'h5, w[17:0]}, leftDataOut);
    // size code 11 writes the mailbox, read back with parity generated
    {right_size_sel_hi, right_size_sel_lo, left_parity_gen_en} <= 3'h7;
    acc(1'h1, 3'h2, 36'h0);
    chk("right flags", 36'h3, {right_full_n, right_almost_full_n});
    acc(1'h0, 3'h1, w);
    chk("mail parity", 36'h804020100, leftDataOut);
    chk("left flags", 36'h0, {left_empty_n, left_almost_empty_n});
    // register bus
    axi(1'h0, 8'h00, 32'h0, rd, rs);
    chk("ctrl reset", 36'h808, rd);
    axi(1'h1, 8'h00, 32'h305, rd, rs);
    chk("wresp", 36'h0, rs);
    axi(1'h0, 8'h00, 32'h0, rd, rs);
    chk("ctrl", 36'h305, rd);
    axi(1'h0, 8'h10, 32'h0, rd, rs);
    chk("unmapped", 36'h2, rs);
    print_verdict();
  end
  // watchdog
  initial begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule
